// *** shared/rsn_defs.svh ***
// Purpose: offsets, field positions, reset values and timing figures of the notify block
// Assumes: 8-bit registers on the 2-wire slave port, 250 MHz core clock
// Notes: times are kept in their own unit; cycle counts are derived in the design
`ifndef RSN_DEFS_SVH
`define RSN_DEFS_SVH
`define RSN_CLK_PERIOD_NS 4
`define RSN_NS_PER_MS 1000000
`define RSN_SCL_KHZ 64
`define RSN_SLAVE_ADDR 7'h0A
`define RSN_APP_ADDR 7'h0B
`define RSN_OFS_MODE_DIS 8'h00
`define RSN_OFS_IRQ_MASK 8'h2F
`define RSN_OFS_IRQ_FACTOR 8'h30
`define RSN_OFS_CONV_STATUS 8'h33
`define RSN_OFS_LOWBAT 8'h34
`define RSN_OFS_UNLOCK 8'h40
`define RSN_PROTECTED_TOP 8'h0F
`define RSN_BIT_UVLO_OK 4
`define RSN_BIT_STARTUP 5
`define RSN_BIT_OVERVOLT 6
`define RSN_BIT_OVERCUR 7
`define RSN_BIT_LB_PULSE 2
`define RSN_RST_MODE_DIS 1'h0
`define RSN_RST_MASK 4'hF
`define RSN_RST_PULSE 1'h0
`define RSN_RST_UNLOCK 1'h0
`define RSN_DLY_DC_OC_MS 8
`define RSN_DLY_BAT_UV_MS 32
`define RSN_DLY_DIS_OC_MS 4
`define RSN_DLY_TJ_MS 256
`define RSN_DLY_LOWBAT_MS 256
`define RSN_LB_H_PERIOD_MS 2560
`define RSN_LB_H_LOW_MS 256
`define RSN_LB_L_PERIOD_MS 1280
`define RSN_LB_L_LOW_MS 128
`endif

// *** shared/rsn_pkg.sv ***
// Purpose: types shared by the notify block and its bench
// Assumes: constants live in rsn_defs.svh
// Notes: sense flags are raw comparator levels from the analog front end
`default_nettype none
package rsn_pkg;
	typedef struct packed {
		logic lowbat_l;
		logic lowbat_h;
		logic tj_hot;
		logic dis_short;
		logic dis_oc;
		logic bat_uv;
		logic reg_ilim;
		logic dc_oc;
		logic fb_ov;
		logic fb_startup;
		logic vcc_ok;
	} rsn_sense_t;
	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [7:0] data;
	} rsn_wpt_req_t;
	typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_PTR, SL_WR, SL_RD} rsn_slave_t;
	typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} rsn_master_t;
endpackage
`default_nettype wire

// *** src/rsn_top.sv ***
// Purpose: converter status, protection response, low-battery, charge/irq, mode pins, 2-wire port
// Assumes: single clock; all pin and comparator inputs are asynchronous
// Notes: open-drain pins drive low while their oe_n is low
// Functional notes
// - converter runs only while the enable pin is high.
// - status bit 4 of 0x33 shows undervoltage released (1) or stopped (0).
// - status bit 5 of 0x33 shows output feedback start-up complete.
// - overvoltage stops switching and sets status bit 6 of 0x33.
// - overcurrent status bit 7 of 0x33 sets after 8 ms persistence.
// - qualify discharge undervoltage 32 ms, discharge overcurrent 4 ms, overtemperature 256 ms.
// - protection opens discharge switch, suspends outputs; overtemperature also suspends charging.
// - battery protection, overtemperature or undervoltage stop the converter regardless of enable.
// - suspend releases mode, charge/irq, low-battery and both bus pins.
// - level mode: low-battery pin low while either level detected.
// - pulse mode, higher level: 256 ms low in every 2560 ms.
// - pulse mode, lower level: 128 ms low in every 1280 ms.
// - bits 1:0 of 0x34 hold both low-battery detection results.
// - thresholds follow converter level; detection qualified for 256 ms.
// - role pin low: unmasked event pulls charge/irq low; host reads factors.
// - role pin high: charge/irq low only during pre, trickle or fast charge.
// - factor bits 0 and 1 set on message and charge change, clear on read.
// - factor bits 2 and 3 follow the 8 ms qualified overcurrent and the live current limit.
// - mask bits 3:0 of 0x2F block sources; all set means charge-status behaviour.
// - mode pin low in charge mode; bit 0 of 0x00 forces it released.
// - role pin picks slave at address 0001010 or master at 64 kHz.
// - slave writes to 0x00..0x0F ignored unless bit 0 of 0x40 set.
// - as master, forward wireless register requests as 2-wire transactions.
`default_nettype none
`include "rsn_defs.svh"
module rsn_top #(
	parameter int TICK_CYCLES = `RSN_NS_PER_MS / `RSN_CLK_PERIOD_NS,
	parameter logic [6:0] APP_ADDR = `RSN_APP_ADDR
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_converter_enable_pin,
	input wire logic i_voltage_select_lo_pin,
	input wire logic i_voltage_select_hi_pin,
	input wire logic i_bus_role_select_pin,
	input wire rsn_pkg::rsn_sense_t i_sense,
	input wire logic i_charge_active,
	input wire logic i_charge_mode,
	input wire logic i_charge_state_change,
	input wire logic i_wpt_msg_rx,
	input wire logic i_wpt_req_valid,
	input wire rsn_pkg::rsn_wpt_req_t i_wpt_req,
	output logic o_wpt_req_ready,
	output logic o_wpt_rsp_valid,
	output logic [7:0] o_wpt_rsp_data,
	output logic o_wpt_rsp_nack,
	input wire logic i_scl,
	output logic o_scl,
	output logic o_scl_oe_n,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	output logic o_converter_run,
	output logic o_converter_switch_en,
	output logic o_discharge_switch_on,
	output logic o_charge_suspend,
	output logic o_lowbat_range_3v0,
	output logic o_mode_pin,
	output logic o_mode_pin_oe_n,
	output logic o_charge_or_irq_pin,
	output logic o_charge_or_irq_pin_oe_n,
	output logic o_low_battery_pin,
	output logic o_low_battery_pin_oe_n
);
	localparam int QUARTER = `RSN_NS_PER_MS / (`RSN_SCL_KHZ * 4 * `RSN_CLK_PERIOD_NS);
	localparam int Q_DCOC = 0;
	localparam int Q_BATUV = 1;
	localparam int Q_DISOC = 2;
	localparam int Q_TJ = 3;
	localparam int Q_LBH = 4;
	localparam int Q_LBL = 5;

	function automatic logic [8:0] qdelay(input int idx);
		case (idx)
			Q_DCOC: qdelay = 9'(`RSN_DLY_DC_OC_MS);
			Q_BATUV: qdelay = 9'(`RSN_DLY_BAT_UV_MS);
			Q_DISOC: qdelay = 9'(`RSN_DLY_DIS_OC_MS);
			Q_TJ: qdelay = 9'(`RSN_DLY_TJ_MS);
			default: qdelay = 9'(`RSN_DLY_LOWBAT_MS);
		endcase
	endfunction

	function automatic logic [7:0] mst_byte(input logic [1:0] idx, input rsn_pkg::rsn_wpt_req_t r);
		case (idx)
			2'h0: mst_byte = {APP_ADDR, 1'h0};
			2'h1: mst_byte = r.addr;
			2'h2: mst_byte = r.write ? r.data : {APP_ADDR, 1'h1};
			default: mst_byte = 8'hFF;
		endcase
	endfunction

	// every pin and comparator level passes two flops; only the second stage is read
	logic [16:0] meta;
	logic [16:0] sync;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			meta <= 17'h1_8000;
			sync <= 17'h1_8000;
		end else begin
			meta <= {i_sda, i_scl, i_bus_role_select_pin, i_voltage_select_hi_pin,
				i_voltage_select_lo_pin, i_converter_enable_pin, i_sense};
			sync <= meta;
		end
	end
	rsn_pkg::rsn_sense_t sn;
	logic en_s;
	logic [1:0] vsel;
	logic role_s;
	logic scl_s;
	logic sda_s;
	assign sn = sync[10:0];
	assign en_s = sync[11];
	assign vsel = sync[13:12];
	assign role_s = sync[14];
	assign scl_s = sync[15];
	assign sda_s = sync[16];

	logic [31:0] tick_cnt;
	logic tick;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
		tick <= i_reset_n && tick_cnt == 32'(TICK_CYCLES - 1);
	end

	// delay qualifiers count whole ms ticks; any dropout restarts the count
	logic [5:0] raw;
	logic [5:0] qual;
	logic [8:0] qcnt [6];
	assign raw = {sn.lowbat_l, sn.lowbat_h, sn.tj_hot, sn.dis_oc, sn.bat_uv, sn.dc_oc};
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < 6; i++) begin
			if (!i_reset_n || !raw[i]) begin
				qcnt[i] <= 9'h0;
			end else if (tick && qcnt[i] < qdelay(i)) begin
				qcnt[i] <= qcnt[i] + 9'h1;
			end
			qual[i] <= i_reset_n && raw[i] && qcnt[i] == qdelay(i);
		end
	end

	logic prot;
	assign prot = qual[Q_BATUV] | qual[Q_DISOC] | sn.dis_short | qual[Q_TJ];

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_converter_run <= 1'h0;
			o_converter_switch_en <= 1'h0;
			o_discharge_switch_on <= 1'h0;
			o_charge_suspend <= 1'h0;
			o_lowbat_range_3v0 <= 1'h0;
		end else begin
			o_converter_run <= en_s && sn.vcc_ok && !prot;
			o_converter_switch_en <= en_s && sn.vcc_ok && !prot && !sn.fb_ov;
			o_discharge_switch_on <= !prot;
			o_charge_suspend <= qual[Q_TJ];
			o_lowbat_range_3v0 <= vsel == 2'h3;
		end
	end

	// registers
	logic mode_dis;
	logic [3:0] mask;
	logic [1:0] fac;
	logic pulse_sel;
	logic unlock;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_clr;
	logic wr_ok;
	logic [3:0] fvec;
	assign wr_ok = wr_stb && (wr_addr > `RSN_PROTECTED_TOP || unlock);
	assign fvec = {sn.reg_ilim, qual[Q_DCOC], fac};
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			mode_dis <= `RSN_RST_MODE_DIS;
			mask <= `RSN_RST_MASK;
			pulse_sel <= `RSN_RST_PULSE;
			unlock <= `RSN_RST_UNLOCK;
		end else if (wr_ok) begin
			case (wr_addr)
				`RSN_OFS_MODE_DIS: mode_dis <= wr_data[0];
				`RSN_OFS_IRQ_MASK: mask <= wr_data[3:0];
				`RSN_OFS_LOWBAT: pulse_sel <= wr_data[`RSN_BIT_LB_PULSE];
				`RSN_OFS_UNLOCK: unlock <= wr_data[0];
				default: ;
			endcase
		end
	end
	// a new event in the clearing cycle survives the read-clear
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			fac <= 2'h0;
		end else begin
			fac <= (fac & {2{!rd_clr}}) | {i_charge_state_change, i_wpt_msg_rx};
		end
	end

	logic [7:0] rd_data;
	logic [7:0] sl_ptr;
	always_comb begin
		rd_data = 8'h00;
		case (sl_ptr)
			`RSN_OFS_MODE_DIS: rd_data = {7'h00, mode_dis};
			`RSN_OFS_IRQ_MASK: rd_data = {4'h0, mask};
			`RSN_OFS_IRQ_FACTOR: rd_data = {4'h0, fvec};
			`RSN_OFS_CONV_STATUS: rd_data = {qual[Q_DCOC], sn.fb_ov, sn.fb_startup, sn.vcc_ok,
				4'h0};
			`RSN_OFS_LOWBAT: rd_data = {5'h00, pulse_sel, qual[Q_LBL], qual[Q_LBH]};
			`RSN_OFS_UNLOCK: rd_data = {7'h00, unlock};
			default: rd_data = 8'h00;
		endcase
	end

	// low-battery pin; the lower level wins since it implies the higher one
	logic [11:0] pcnt;
	logic lb_any;
	logic lb_low;
	logic [11:0] lb_period;
	logic [11:0] lb_width;
	assign lb_any = qual[Q_LBH] | qual[Q_LBL];
	assign lb_period = qual[Q_LBL] ? 12'(`RSN_LB_L_PERIOD_MS) : 12'(`RSN_LB_H_PERIOD_MS);
	assign lb_width = qual[Q_LBL] ? 12'(`RSN_LB_L_LOW_MS) : 12'(`RSN_LB_H_LOW_MS);
	assign lb_low = pulse_sel ? (lb_any && pcnt < lb_width) : lb_any;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !lb_any || !pulse_sel) begin
			pcnt <= 12'h0;
		end else if (tick) begin
			pcnt <= (pcnt >= lb_period - 12'h1) ? 12'h0 : pcnt + 12'h1;
		end
	end

	logic chg_style;
	logic irq_pend;
	logic sl_sda_low;
	logic mst_sda_low;
	assign chg_style = role_s || (&mask);
	assign irq_pend = |(fvec & ~mask);
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_mode_pin_oe_n <= 1'h1;
			o_charge_or_irq_pin_oe_n <= 1'h1;
			o_low_battery_pin_oe_n <= 1'h1;
			o_sda_oe_n <= 1'h1;
		end else begin
			o_mode_pin_oe_n <= !(i_charge_mode && !mode_dis && !prot);
			o_charge_or_irq_pin_oe_n <= !((chg_style ? i_charge_active : irq_pend) && !prot);
			o_low_battery_pin_oe_n <= !(lb_low && !prot);
			o_sda_oe_n <= !(sl_sda_low || mst_sda_low);
		end
	end
	assign o_mode_pin = 1'h0;
	assign o_charge_or_irq_pin = 1'h0;
	assign o_low_battery_pin = 1'h0;
	assign o_scl = 1'h0;
	assign o_sda = 1'h0;

	// 2-wire slave on sampled lines; never stretches the clock
	rsn_pkg::rsn_slave_t sl_state;
	logic scl_d;
	logic sda_d;
	logic sl_ack;
	logic sl_rw;
	logic [3:0] sl_cnt;
	logic [7:0] sl_sh;
	logic [7:0] sl_rsh;
	logic scl_rise;
	logic scl_fall;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	always_ff @(posedge i_clk) begin
		scl_d <= scl_s;
		sda_d <= sda_s;
		wr_stb <= 1'h0;
		rd_clr <= 1'h0;
		if (!i_reset_n || role_s || prot) begin
			sl_state <= rsn_pkg::SL_IDLE;
			sl_sda_low <= 1'h0;
			sl_ack <= 1'h0;
			sl_cnt <= 4'h0;
			sl_ptr <= 8'h00;
			sl_rw <= 1'h0;
			sl_sh <= 8'h00;
			sl_rsh <= 8'h00;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else if (scl_s && scl_d && sda_d && !sda_s) begin
			sl_state <= rsn_pkg::SL_ADDR;
			sl_cnt <= 4'h0;
			sl_ack <= 1'h0;
			sl_sda_low <= 1'h0;
		end else if (scl_s && scl_d && !sda_d && sda_s) begin
			sl_state <= rsn_pkg::SL_IDLE;
			sl_sda_low <= 1'h0;
		end else if (scl_rise && sl_state != rsn_pkg::SL_IDLE) begin
			if (!sl_ack) begin
				sl_sh <= {sl_sh[6:0], sda_s};
				sl_cnt <= sl_cnt + 4'h1;
			end else if (sl_state == rsn_pkg::SL_RD && sda_s) begin
				sl_state <= rsn_pkg::SL_IDLE;
			end
		end else if (scl_fall && sl_state != rsn_pkg::SL_IDLE) begin
			if (!sl_ack && sl_cnt == 4'h8) begin
				sl_ack <= 1'h1;
				sl_cnt <= 4'h0;
				case (sl_state)
					rsn_pkg::SL_ADDR: begin
						if (sl_sh[7:1] == `RSN_SLAVE_ADDR) begin
							sl_sda_low <= 1'h1;
							sl_rw <= sl_sh[0];
						end else begin
							sl_state <= rsn_pkg::SL_IDLE;
						end
					end
					rsn_pkg::SL_PTR: begin
						sl_ptr <= sl_sh;
						sl_sda_low <= 1'h1;
					end
					rsn_pkg::SL_WR: begin
						wr_stb <= 1'h1;
						wr_addr <= sl_ptr;
						wr_data <= sl_sh;
						sl_ptr <= sl_ptr + 8'h1;
						sl_sda_low <= 1'h1;
					end
					rsn_pkg::SL_RD: begin
						sl_sda_low <= 1'h0;
						sl_ptr <= sl_ptr + 8'h1;
					end
					default: sl_state <= rsn_pkg::SL_IDLE;
				endcase
			end else if (sl_ack) begin
				sl_ack <= 1'h0;
				if ((sl_state == rsn_pkg::SL_ADDR && sl_rw) || sl_state == rsn_pkg::SL_RD) begin
					sl_state <= rsn_pkg::SL_RD;
					sl_sda_low <= !rd_data[7];
					sl_rsh <= {rd_data[6:0], 1'h0};
					sl_cnt <= 4'h0;
					rd_clr <= sl_ptr == `RSN_OFS_IRQ_FACTOR;
				end else begin
					sl_sda_low <= 1'h0;
					sl_state <= (sl_state == rsn_pkg::SL_ADDR) ? rsn_pkg::SL_PTR : rsn_pkg::SL_WR;
				end
			end else if (sl_state == rsn_pkg::SL_RD) begin
				sl_sda_low <= !sl_rsh[7];
				sl_rsh <= {sl_rsh[6:0], 1'h0};
			end
		end
	end

	// 2-wire master: each bit is four quarter periods of the 64 kHz clock
	rsn_pkg::rsn_master_t m_state;
	rsn_pkg::rsn_wpt_req_t m_req;
	logic [11:0] m_div;
	logic m_q;
	logic [1:0] m_ph;
	logic [3:0] m_bit;
	logic [1:0] m_idx;
	logic [7:0] m_sh;
	logic m_last;
	assign m_q = m_div == 12'(QUARTER - 1);
	assign m_last = m_req.write ? (m_idx == 2'h2) : (m_idx == 2'h3);
	always_ff @(posedge i_clk) begin
		o_wpt_rsp_valid <= 1'h0;
		o_wpt_req_ready <= 1'h0;
		if (!i_reset_n || !role_s || prot) begin
			m_state <= rsn_pkg::M_IDLE;
			m_div <= 12'h0;
			m_ph <= 2'h0;
			m_bit <= 4'h0;
			m_idx <= 2'h0;
			m_sh <= 8'h00;
			m_req <= '0;
			mst_sda_low <= 1'h0;
			o_scl_oe_n <= 1'h1;
			o_wpt_rsp_data <= 8'h00;
			o_wpt_rsp_nack <= 1'h0;
		end else begin
			m_div <= m_q ? 12'h0 : m_div + 12'h1;
			case (m_state)
				rsn_pkg::M_IDLE: begin
					if (i_wpt_req_valid && o_wpt_req_ready) begin
						m_req <= i_wpt_req;
						m_state <= rsn_pkg::M_START;
						m_idx <= 2'h0;
						m_ph <= 2'h0;
						o_wpt_rsp_nack <= 1'h0;
					end else begin
						o_wpt_req_ready <= 1'h1;
					end
				end
				rsn_pkg::M_START: if (m_q) begin
					m_ph <= m_ph + 2'h1;
					case (m_ph)
						2'h0: mst_sda_low <= 1'h0;
						2'h1: o_scl_oe_n <= 1'h1;
						2'h2: mst_sda_low <= 1'h1;
						default: begin
							o_scl_oe_n <= 1'h0;
							m_state <= rsn_pkg::M_BYTE;
							m_bit <= 4'h0;
							m_sh <= mst_byte(m_idx, m_req);
						end
					endcase
				end
				rsn_pkg::M_BYTE: if (m_q) begin
					m_ph <= m_ph + 2'h1;
					case (m_ph)
						2'h0: begin
							o_scl_oe_n <= 1'h0;
							mst_sda_low <= (m_bit < 4'h8) ? !m_sh[7] : 1'h0;
						end
						2'h1: ;
						2'h2: o_scl_oe_n <= 1'h1;
						default: begin
							o_scl_oe_n <= 1'h0;
							m_bit <= m_bit + 4'h1;
							if (m_bit < 4'h8) begin
								m_sh <= {m_sh[6:0], sda_s};
							end else begin
								if (m_idx != 2'h3) begin
									o_wpt_rsp_nack <= o_wpt_rsp_nack | sda_s;
								end else begin
									o_wpt_rsp_data <= m_sh;
								end
								m_bit <= 4'h0;
								m_idx <= m_idx + 2'h1;
								m_sh <= mst_byte(m_idx + 2'h1, m_req);
								if (m_last) begin
									m_state <= rsn_pkg::M_STOP;
								end else if (!m_req.write && m_idx == 2'h1) begin
									m_state <= rsn_pkg::M_START;
								end
							end
						end
					endcase
				end
				rsn_pkg::M_STOP: if (m_q) begin
					m_ph <= m_ph + 2'h1;
					case (m_ph)
						2'h0: mst_sda_low <= 1'h1;
						2'h1: o_scl_oe_n <= 1'h1;
						2'h2: mst_sda_low <= 1'h0;
						default: begin
							m_state <= rsn_pkg::M_IDLE;
							o_wpt_rsp_valid <= 1'h1;
						end
					endcase
				end
				default: m_state <= rsn_pkg::M_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_conv_prot_stop: assert property (prot |=> !o_converter_run)
		else $error("converter runs under protection");
	a_ov_switch_off: assert property (sn.fb_ov |=> !o_converter_switch_en)
		else $error("switching during overvoltage");
	a_oc_delay_exact: assert property ($rose(qual[Q_DCOC]) |->
		$past(qcnt[Q_DCOC]) == 9'(`RSN_DLY_DC_OC_MS))
		else $error("overcurrent qualified at wrong delay");
	a_lowbat_level: assert property ((!pulse_sel && lb_any && !prot) |=>
		!o_low_battery_pin_oe_n)
		else $error("low-battery pin not low in level mode");
	a_role_charge: assert property ((role_s && !prot) |=>
		o_charge_or_irq_pin_oe_n == !$past(i_charge_active))
		else $error("charge pin does not follow charging");
	a_factor_clear: assert property ((rd_clr && !i_wpt_msg_rx && !i_charge_state_change) |=>
		fac == 2'h0)
		else $error("factor not cleared by read");
	a_suspend_pins: assert property (prot ##1 prot |=>
		o_mode_pin_oe_n && o_low_battery_pin_oe_n
		&& o_charge_or_irq_pin_oe_n && o_scl_oe_n && o_sda_oe_n)
		else $error("pin driven during suspend");
	a_unlock_guard: assert property ((wr_stb && wr_addr <= `RSN_PROTECTED_TOP && !unlock) |=>
		$stable(mode_dis))
		else $error("locked register written");
	a_irq_release: assert property ((!chg_style && !irq_pend && !prot) |=>
		o_charge_or_irq_pin_oe_n)
		else $error("irq pin held without pending factor");
	a_mode_disable: assert property (mode_dis |=> o_mode_pin_oe_n)
		else $error("mode pin driven while disabled");
	c_pulse_low: cover property (pulse_sel && qual[Q_LBL] && !o_low_battery_pin_oe_n);
	c_master_done: cover property (o_wpt_rsp_valid && !o_wpt_rsp_nack);
	c_slave_write: cover property (wr_ok);
endmodule
`default_nettype wire

// *** verification/rsn_app_model.sv ***
// Purpose: application-system bus master on the 2-wire slave port
// Assumes: open-drain lines; an output at 1 releases the line
// Notes: a quarter bit is 10 core cycles, so one bit lasts 160 ns
`default_nettype none
`include "rsn_defs.svh"
module rsn_app_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output var logic o_scl,
	output var logic o_sda
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// lines move just after a core edge, never on it
	task automatic q();
		repeat (10) @(posedge i_clk);
		#1;
	endtask
	task automatic start();
		o_sda = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		o_sda = 1'b0;
		q();
		o_scl = 1'b0;
		q();
	endtask
	task automatic stop();
		o_sda = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		o_sda = 1'b1;
		q();
	endtask
	// eight bits msb first, then the acknowledge slot; data only moves while clock is low
	task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			o_sda = tx[i];
			q();
			o_scl = 1'b1;
			q();
			rx[i] = i_sda;
			q();
			o_scl = 1'b0;
			q();
		end
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
		output logic ok);
		logic [8:0] r0;
		logic [8:0] r1;
		logic [8:0] r2;
		start();
		bits9({dev, 1'b0, 1'b1}, r0);
		bits9({ptr, 1'b1}, r1);
		bits9({d, 1'b1}, r2);
		stop();
		ok = ~(r0[0] | r1[0] | r2[0]);
	endtask
	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		logic [8:0] r;
		start();
		bits9({`RSN_SLAVE_ADDR, 1'b0, 1'b1}, r);
		bits9({ptr, 1'b1}, r);
		start();
		bits9({`RSN_SLAVE_ADDR, 1'b1, 1'b1}, r);
		// single byte, closed by a not-acknowledge
		bits9({8'hFF, 1'b1}, r);
		stop();
		d = r[8:1];
	endtask
endmodule
`default_nettype wire

// *** verification/test_receiver_status_notify_logic.sv ***
// Purpose: self-checking bench of the notify block via its slave port and pins
// Assumes: ms tick shortened to TICK core cycles
// Notes: wireless requests stay idle; master forwarding is left unexercised
`default_nettype none
`include "rsn_defs.svh"
`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
	end \
end
module test_receiver_status_notify_logic;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 5;
	int mismatches = 0;
	int tests_run = 0;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic en = 1'b0;
	logic sel_lo = 1'b0;
	logic sel_hi = 1'b0;
	logic role = 1'b0;
	rsn_pkg::rsn_sense_t sense = '0;
	logic chg_act = 1'b0;
	logic chg_mode = 1'b0;
	logic chg_chg = 1'b0;
	logic msg_rx = 1'b0;
	logic app_scl, app_sda, scl_oe_n, sda_oe_n, run, sw_en, dis_on, suspend, range_3v0;
	logic mode_oe_n, irq_oe_n, lb_oe_n, ok;
	logic [7:0] d;
	// pull-ups on both bus lines
	wire logic scl_line = app_scl & scl_oe_n;
	wire logic sda_line = app_sda & sda_oe_n;
	always #2 clk = ~clk;
	rsn_top #(.TICK_CYCLES(TICK)) uut (.i_clk(clk), .i_reset_n(reset_n),
		.i_converter_enable_pin(en), .i_voltage_select_lo_pin(sel_lo),
		.i_voltage_select_hi_pin(sel_hi), .i_bus_role_select_pin(role), .i_sense(sense),
		.i_charge_active(chg_act), .i_charge_mode(chg_mode), .i_charge_state_change(chg_chg),
		.i_wpt_msg_rx(msg_rx), .i_wpt_req_valid(1'b0), .i_wpt_req('0), .o_wpt_req_ready(),
		.o_wpt_rsp_valid(), .o_wpt_rsp_data(), .o_wpt_rsp_nack(), .i_scl(scl_line), .o_scl(),
		.o_scl_oe_n(scl_oe_n), .i_sda(sda_line), .o_sda(), .o_sda_oe_n(sda_oe_n),
		.o_converter_run(run), .o_converter_switch_en(sw_en), .o_discharge_switch_on(dis_on),
		.o_charge_suspend(suspend), .o_lowbat_range_3v0(range_3v0), .o_mode_pin(),
		.o_mode_pin_oe_n(mode_oe_n), .o_charge_or_irq_pin(), .o_charge_or_irq_pin_oe_n(irq_oe_n),
		.o_low_battery_pin(), .o_low_battery_pin_oe_n(lb_oe_n));
	rsn_app_model app (.i_clk(clk), .i_sda(sda_line), .o_scl(app_scl), .o_sda(app_sda));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] m, input logic [7:0] e);
		app.rd(ptr, d);
		`CHK(d & m, e)
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
		app.wr(`RSN_SLAVE_ADDR, ptr, v, ok);
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	// skips any partial pulse, then times one whole low pulse and its period
	task automatic meas(output int lo, output int per);
		int n = 0;
		lo = 0;
		while (lb_oe_n !== 1'b1 && n < 30000) begin
			cyc(1);
			n++;
		end
		while (lb_oe_n === 1'b1 && n < 60000) begin
			cyc(1);
			n++;
		end
		while (lb_oe_n === 1'b0 && lo < 30000) begin
			cyc(1);
			lo++;
		end
		per = lo;
		while (lb_oe_n === 1'b1 && per < 30000) begin
			cyc(1);
			per++;
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (95000) @(posedge clk);
		mismatches++;
		$display("watchdog expired");
		end_sim();
	end
	initial begin
		static int pos[4] = '{5, 6, 8, 7};
		static int dly[4] = '{32, 4, 256, 0};
		int lo;
		int per;
		cyc(10);
		reset_n = 1'b1;
		cyc(5);
		rd_chk(8'h00, 8'hFF, 8'h00);
		rd_chk(8'h2F, 8'hFF, 8'h0F);
		rd_chk(8'h40, 8'hFF, 8'h00);
		done("reset values");
		app.wr(7'h0B, 8'h00, 8'h01, ok);
		`CHK(ok, 1'b0)
		wr(8'h00, 8'h01);
		`CHK(ok, 1'b1)
		rd_chk(8'h00, 8'hFF, 8'h00);
		chg_mode = 1'b1;
		cyc(5);
		`CHK(mode_oe_n, 1'b0)
		wr(8'h40, 8'h01);
		wr(8'h00, 8'h01);
		rd_chk(8'h00, 8'hFF, 8'h01);
		`CHK(mode_oe_n, 1'b1)
		wr(8'h00, 8'h00);
		cyc(5);
		`CHK(mode_oe_n, 1'b0)
		done("write lock and mode pin");
		en = 1'b1;
		sel_hi = 1'b1;
		sel_lo = 1'b1;
		sense.vcc_ok = 1'b1;
		sense.fb_startup = 1'b1;
		cyc(5);
		`CHK({run, sw_en, range_3v0}, 3'b111)
		rd_chk(8'h33, 8'hF0, 8'h30);
		sense.fb_ov = 1'b1;
		cyc(5);
		`CHK(sw_en, 1'b0)
		rd_chk(8'h33, 8'hF0, 8'h70);
		sense.fb_ov = 1'b0;
		sense.vcc_ok = 1'b0;
		cyc(5);
		`CHK(run, 1'b0)
		rd_chk(8'h33, 8'hF0, 8'h20);
		sense.vcc_ok = 1'b1;
		en = 1'b0;
		sel_hi = 1'b0;
		cyc(5);
		`CHK({run, range_3v0}, 2'b00)
		en = 1'b1;
		done("converter status");
		wr(8'h2F, 8'h04);
		sense.reg_ilim = 1'b1;
		msg_rx = 1'b1;
		chg_chg = 1'b1;
		cyc(1);
		msg_rx = 1'b0;
		chg_chg = 1'b0;
		cyc(5);
		`CHK(irq_oe_n, 1'b0)
		rd_chk(8'h30, 8'h0F, 8'h0B);
		rd_chk(8'h30, 8'h0F, 8'h08);
		`CHK(irq_oe_n, 1'b0)
		sense.reg_ilim = 1'b0;
		cyc(5);
		`CHK(irq_oe_n, 1'b1)
		wr(8'h2F, 8'h0B);
		sense.dc_oc = 1'b1;
		cyc(8 * TICK - 10);
		`CHK(irq_oe_n, 1'b1)
		cyc(TICK + 20);
		`CHK(irq_oe_n, 1'b0)
		rd_chk(8'h33, 8'h80, 8'h80);
		sense.dc_oc = 1'b0;
		cyc(5);
		`CHK(irq_oe_n, 1'b1)
		wr(8'h2F, 8'h0F);
		chg_act = 1'b1;
		cyc(5);
		`CHK(irq_oe_n, 1'b0)
		chg_act = 1'b0;
		role = 1'b1;
		cyc(5);
		`CHK(irq_oe_n, 1'b1)
		chg_act = 1'b1;
		cyc(5);
		`CHK(irq_oe_n, 1'b0)
		role = 1'b0;
		done("interrupt factors");
		for (int i = 0; i < 4; i++) begin
			sense[pos[i]] = 1'b1;
			if (dly[i] > 0) begin
				cyc(dly[i] * TICK - 10);
				`CHK(dis_on, 1'b1)
			end
			cyc(40);
			`CHK({dis_on, run, mode_oe_n, irq_oe_n, lb_oe_n}, 5'b00111)
			`CHK(suspend, pos[i] == 8)
			sense[pos[i]] = 1'b0;
			cyc(5);
			`CHK({dis_on, run, suspend, irq_oe_n}, 4'b1100)
		end
		chg_act = 1'b0;
		done("protection");
		sense.lowbat_h = 1'b1;
		cyc(255 * TICK);
		`CHK(lb_oe_n, 1'b1)
		cyc(2 * TICK + 10);
		`CHK(lb_oe_n, 1'b0)
		rd_chk(8'h34, 8'h03, 8'h01);
		wr(8'h34, 8'h04);
		meas(lo, per);
		`CHK(lo, 256 * TICK)
		`CHK(per, 2560 * TICK)
		sense.lowbat_l = 1'b1;
		cyc(260 * TICK);
		rd_chk(8'h34, 8'h03, 8'h03);
		meas(lo, per);
		`CHK(lo, 128 * TICK)
		`CHK(per, 1280 * TICK)
		wr(8'h34, 8'h00);
		sense.lowbat_h = 1'b0;
		sense.lowbat_l = 1'b0;
		cyc(260 * TICK);
		`CHK(lb_oe_n, 1'b1)
		rd_chk(8'h34, 8'h07, 8'h00);
		done("low battery");
		end_sim();
	end
endmodule
`default_nettype wire
